// ==== hw/pbg_pkg.sv ====
// Package: constants for the port pin function and GPIO block
package pbg_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int          PIN_COUNT   = 15;
  localparam int          ADDR_WIDTH  = 16;
  localparam int          DATA_WIDTH  = 24;
  localparam int          ACK_PIN     = 14;

  // ----------------------------------------
  // Register word addresses in X peripheral space
  // ----------------------------------------
  localparam logic [15:0] ADDR_FUNC_SELECT = 16'hFFEC;
  localparam logic [15:0] ADDR_DIRECTION   = 16'hFFED;
  localparam logic [15:0] ADDR_DATA        = 16'hFFEE;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0]  FUNC_RESET  = 2'h0;
  localparam logic [14:0] DIR_RESET   = 15'h0000;
  localparam logic [14:0] DATA_RESET  = 15'h0000;
  localparam logic [23:0] RDATA_RESET = 24'h000000;

  // ----------------------------------------
  // Field positions and read padding
  // ----------------------------------------
  localparam int          FUNC_MSB    = 1;
  localparam int          FUNC_LSB    = 0;
  localparam int          PIN_MSB     = 14;
  localparam int          PIN_LSB     = 0;
  localparam logic [21:0] FUNC_PAD    = 22'h000000;
  localparam logic [8:0]  PIN_PAD     = 9'h000;
  localparam logic [23:0] READ_ZERO   = 24'h000000;

  // ----------------------------------------
  // Function codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PBG_FUNC_GPIO     = 2'b00,
    PBG_FUNC_HOST     = 2'b01,
    PBG_FUNC_HOST_ACK = 2'b10,
    PBG_FUNC_RSVD     = 2'b11
  } pbg_func_type;

endpackage : pbg_pkg

// ==== hw/pbg_pin_cell.sv ====
// Module: one port pin, its ownership, drive and readback selection
`timescale 1ns/10ps
`default_nettype none

module pbg_pin_cell (
  input  wire logic host_owned,
  input  wire logic dir_bit,
  input  wire logic data_bit,
  input  wire logic pin_level,
  input  wire logic host_out,
  input  wire logic host_oe,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      read_bit
);

  // ----------------------------------------
  // Drive and readback
  // ----------------------------------------
  wire logic gpio_drive;

  assign gpio_drive = ~host_owned & dir_bit;
  assign pin_oe     = host_owned ? host_oe : gpio_drive;
  assign pin_out    = host_owned ? host_out : data_bit;
  assign read_bit   = dir_bit ? data_bit : pin_level;

endmodule : pbg_pin_cell

`default_nettype wire

// ==== hw/pbg_port.sv ====
// Module: port function select, direction and data registers over fifteen pins
// Behaviour
// - Reset clears function select and direction, all pins become inputs.
// - Code 0 gives GPIO, 1 gives host port, 2 host port without acknowledge.
// - With code 2 the acknowledge pin acts as GPIO pin 14.
// - GPIO direction bit 0 means input, 1 means driven output.
// - Input pin reads live level; writes latch but pin stays undriven.
// - Output pin drives written data from the next cycle.
// - Output pin reads latched register contents.
// - Host pin with direction 0 reads live pin level.
// - Host pin with direction 1 reads latched contents.
// - Registers sit at word addresses FFEC, FFED, FFEE.
// - Data bit n maps to pin n for all fifteen pins.
// - No hardware strobe; software toggles an output pin instead.
`timescale 1ns/10ps
`default_nettype none

module pbg_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] per_addr,
  input  wire logic        per_wr,
  input  wire logic        per_rd,
  input  wire logic [23:0] per_wdata,
  output logic      [23:0] per_rdata,
  output logic             per_sel,
  input  wire logic [14:0] pin_in,
  output logic      [14:0] pin_out,
  output logic      [14:0] pin_oe,
  input  wire logic [14:0] host_out,
  input  wire logic [14:0] host_oe,
  output logic             host_enable,
  output logic             host_ack_enable
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [1:0]  func_q;
  logic [1:0]  func_d;
  logic [14:0] dir_q;
  logic [14:0] dir_d;
  logic [14:0] data_q;
  logic [14:0] data_d;
  logic [23:0] rdata_q;
  logic [23:0] rdata_d;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic        hit_func;
  wire logic        hit_dir;
  wire logic        hit_data;

  assign hit_func = (per_addr == pbg_pkg::ADDR_FUNC_SELECT);
  assign hit_dir  = (per_addr == pbg_pkg::ADDR_DIRECTION);
  assign hit_data = (per_addr == pbg_pkg::ADDR_DATA);
  assign per_sel  = hit_func | hit_dir | hit_data;

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  wire logic wr_func;
  wire logic wr_dir;
  wire logic wr_data;

  assign wr_func = per_wr & hit_func;
  assign wr_dir  = per_wr & hit_dir;
  assign wr_data = per_wr & hit_data;

  // ----------------------------------------
  // Read strobes
  // ----------------------------------------
  wire logic rd_func;
  wire logic rd_dir;
  wire logic rd_data;
  wire logic rd_unmapped;

  assign rd_func     = per_rd & hit_func;
  assign rd_dir      = per_rd & hit_dir;
  assign rd_data     = per_rd & hit_data;
  assign rd_unmapped = per_rd & ~per_sel;

  // ----------------------------------------
  // Write fields
  // ----------------------------------------
  wire logic [1:0]  wr_func_field;
  wire logic [14:0] wr_dir_field;
  wire logic [14:0] wr_data_field;

  assign wr_func_field = per_wdata[pbg_pkg::FUNC_MSB:pbg_pkg::FUNC_LSB];
  assign wr_dir_field  = per_wdata[pbg_pkg::PIN_MSB:pbg_pkg::PIN_LSB];
  assign wr_data_field = per_wdata[pbg_pkg::PIN_MSB:pbg_pkg::PIN_LSB];

  // ----------------------------------------
  // Function code decode
  // ----------------------------------------
  pbg_pkg::pbg_func_type func_code;
  wire logic             mode_gpio;
  wire logic             mode_host_ack;
  wire logic             mode_rsvd;
  wire logic             all_gpio;

  assign func_code     = pbg_pkg::pbg_func_type'(func_q);
  assign mode_gpio     = (func_code == pbg_pkg::PBG_FUNC_GPIO);
  assign mode_host_ack = (func_code == pbg_pkg::PBG_FUNC_HOST_ACK);
  assign mode_rsvd     = (func_code == pbg_pkg::PBG_FUNC_RSVD);
  assign all_gpio      = mode_gpio | mode_rsvd;

  // ----------------------------------------
  // Function ownership
  // ----------------------------------------
  assign host_enable     = ~all_gpio;
  assign host_ack_enable = host_enable & ~mode_host_ack;

  // ----------------------------------------
  // Pin cells
  // ----------------------------------------
  wire logic [14:0] host_owned;
  wire logic [14:0] read_bits;

  genvar gi;
  generate
    for (gi = 0; gi < pbg_pkg::PIN_COUNT; gi++) begin : g_pin
      if (gi == pbg_pkg::ACK_PIN) begin : g_ack
        assign host_owned[gi] = host_ack_enable;
      end else begin : g_plain
        assign host_owned[gi] = host_enable;
      end
      pbg_pin_cell u_cell (
        .host_owned (host_owned[gi]),
        .dir_bit    (dir_q[gi]),
        .data_bit   (data_q[gi]),
        .pin_level  (pin_in[gi]),
        .host_out   (host_out[gi]),
        .host_oe    (host_oe[gi]),
        .pin_out    (pin_out[gi]),
        .pin_oe     (pin_oe[gi]),
        .read_bit   (read_bits[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read words
  // ----------------------------------------
  wire logic [23:0] func_word;
  wire logic [23:0] dir_word;
  wire logic [23:0] data_word;

  assign func_word = {pbg_pkg::FUNC_PAD, func_q};
  assign dir_word  = {pbg_pkg::PIN_PAD, dir_q};
  assign data_word = {pbg_pkg::PIN_PAD, read_bits};

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  assign func_d = wr_func ? wr_func_field : func_q;
  assign dir_d  = wr_dir ? wr_dir_field : dir_q;
  assign data_d = wr_data ? wr_data_field : data_q;

  // ----------------------------------------
  // Read data next value
  // ----------------------------------------
  assign rdata_d = rd_func     ? func_word :
                   rd_dir      ? dir_word :
                   rd_data     ? data_word :
                   rd_unmapped ? pbg_pkg::READ_ZERO :
                                 rdata_q;

  // ----------------------------------------
  // Function select register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      func_q <= pbg_pkg::FUNC_RESET;
    end else begin
      func_q <= func_d;
    end
  end

  // ----------------------------------------
  // Direction register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_q <= pbg_pkg::DIR_RESET;
    end else begin
      dir_q <= dir_d;
    end
  end

  // ----------------------------------------
  // Data register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= pbg_pkg::DATA_RESET;
    end else begin
      data_q <= data_d;
    end
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= pbg_pkg::RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign per_rdata = rdata_q;

endmodule : pbg_port

`default_nettype wire

// ==== testbench/pbg_port_checker.sv ====
// Checker: port block assertions
`timescale 1ns/10ps
`default_nettype none
module pbg_port_checker (
  input wire logic        clk, rst, per_wr, per_rd, per_sel, host_enable, host_ack_enable,
  input wire logic [15:0] per_addr,
  input wire logic [23:0] per_wdata, per_rdata,
  input wire logic [14:0] pin_out, pin_oe
);
  logic [23:0] w_q;
  wire f_wr = per_wr && per_addr == 16'hFFEC;
  wire d_wr = per_wr && per_addr == 16'hFFED;
  wire q_wr = per_wr && per_addr == 16'hFFEE;
  always_ff @(posedge clk) w_q <= per_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> pin_oe == 15'h0 && !host_enable; endproperty
  property p_fn; f_wr |=> host_enable == (w_q[1:0] == 2'h1 || w_q[1:0] == 2'h2); endproperty
  property p_ack; f_wr |=> host_ack_enable == (w_q[1:0] == 2'h1); endproperty
  property p_sel; per_sel == (per_addr inside {16'hFFEC, 16'hFFED, 16'hFFEE}); endproperty
  property p_unm; per_rd && !per_sel |=> per_rdata == 24'h0; endproperty
  property p_hold; !per_rd |=> $stable(per_rdata); endproperty
  property p_dir; d_wr && !host_enable |=> pin_oe[13:0] == w_q[13:0]; endproperty
  property p_drv; q_wr && !host_enable |=> (pin_out[13:0] & pin_oe[13:0]) == (w_q[13:0] & pin_oe[13:0]); endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
  a_fn: assert property (p_fn) else $error("host ownership wrong");
  a_ack: assert property (p_ack) else $error("acknowledge ownership wrong");
  a_sel: assert property (p_sel) else $error("select decode wrong");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_dir: assert property (p_dir) else $error("enable not from direction");
  a_drv: assert property (p_drv) else $error("pin value not latched data");
  c_fn: cover property (f_wr);
  c_host: cover property (q_wr && host_enable);
  c_unm: cover property (per_rd && !per_sel);
endmodule : pbg_port_checker
bind pbg_port pbg_port_checker i_chk (.*);
`default_nettype wire

// ==== testbench/pbg_pins_model.sv ====
// Model: outside circuitry on the fifteen pins
`timescale 1ns/10ps
`default_nettype none
module pbg_pins_model (
  input  wire logic [14:0] pin_out, pin_oe, ext_level,
  output logic      [14:0] pin_in
);
  // Driven pins show the port value, released ones the outside level
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pbg_pins_model
`default_nettype wire

// ==== testbench/pbg_port_tb.sv ====
// Testbench: register accesses and pin checks
`timescale 1ns/10ps
`default_nettype none
module pbg_port_tb;
  logic        clk = 1'b0, rst = 1'b1, per_wr = 1'b0, per_rd = 1'b0, per_sel, host_enable, host_ack_enable;
  logic [15:0] per_addr = 16'h0;
  logic [23:0] per_wdata = 24'h0, per_rdata;
  logic [14:0] pin_in, pin_out, pin_oe, host_out = 15'h0033, host_oe = 15'h7FFF, ext_level = 15'h00A5;
  int          fail_count = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  pbg_port i_dut (.*);
  pbg_pins_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] a, input logic [23:0] d);
    @(posedge clk);
    #2;
    per_wr = w;
    per_rd = !w;
    per_addr = a;
    per_wdata = d;
    @(posedge clk);
    #2;
    per_wr = 1'b0;
    per_rd = 1'b0;
  endtask : acc
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    chk("pin_oe", 24'h0, {9'h0, pin_oe});
    acc(1'b1, 16'hFFEC, 24'h0);
    acc(1'b1, 16'hFFED, 24'h7F00);
    acc(1'b1, 16'hFFEE, 24'h4100);
    chk("pin_oe", 24'h7F00, {9'h0, pin_oe});
    chk("pin_out", 24'h4100, {9'h0, pin_out & pin_oe});
    acc(1'b0, 16'hFFEE, 24'h0);
    chk("pin_data", 24'h41A5, per_rdata);
    $display("gpio test done");
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 16'hFFEC, 24'(c));
      chk("host_enable", 24'(c == 1 || c == 2), {23'h0, host_enable});
      chk("pin_out14", 24'(c != 1), {23'h0, pin_out[14]});
      acc(1'b0, 16'hFFEE, 24'h0);
      chk("pin_data", (c == 1 || c == 2) ? 24'h4133 : 24'h41A5, per_rdata);
    end
    host_oe = 15'h0000;
    acc(1'b1, 16'hFFEC, 24'h1);
    acc(1'b0, 16'hFFEE, 24'h0);
    chk("pin_data", 24'h41A5, per_rdata);
    acc(1'b1, 16'hFFEF, 24'h3);
    acc(1'b0, 16'hFFEC, 24'h0);
    chk("function", 24'h1, per_rdata);
    acc(1'b0, 16'hFFEF, 24'h0);
    chk("unmapped", 24'h0, per_rdata);
    $display("mode test done");
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    rst = 1'b0;
    chk("pin_oe", 24'h0, {9'h0, pin_oe});
    chk("host_enable", 24'h0, {23'h0, host_enable});
    acc(1'b0, 16'hFFED, 24'h0);
    chk("direction", 24'h0, per_rdata);
    $display("reset test done");
    end_of_test();
  end
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule : pbg_port_tb
`default_nettype wire
